// File: verilog/tic_pkg.sv
// Constants for the threshold and interrupt configuration bank.
// Assumes one core clock; all pins are resynchronised before use.
package tic_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int RES_W  = 16;
  localparam int FUNC_W = 6;
  localparam int BCNT_W = 3;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_RP_UPPER_LO = 7'h06;
  localparam logic [ADDR_W-1:0] ADDR_RP_UPPER_HI = 7'h07;
  localparam logic [ADDR_W-1:0] ADDR_RP_LOWER_LO = 7'h08;
  localparam logic [ADDR_W-1:0] ADDR_RP_LOWER_HI = 7'h09;
  localparam logic [ADDR_W-1:0] ADDR_ISEL        = 7'h0a;
  localparam logic [ADDR_W-1:0] ADDR_FMODE       = 7'h0b;
  localparam logic [ADDR_W-1:0] ADDR_ONE         = 7'h01;

  // Reset values
  localparam logic [DATA_W-1:0] THR_RST   = 8'h00;
  localparam logic [DATA_W-1:0] ISEL_RST  = 8'h00;
  localparam logic [DATA_W-1:0] FMODE_RST = 8'h01;
  localparam logic [DATA_W-1:0] RD_NONE   = 8'h00;

  // Field positions
  localparam int ISEL_SDO_BIT  = 7;
  localparam int ISEL_FUNC_MSB = 5;
  localparam int SPI_RW_BIT    = 7;
  localparam logic [BCNT_W-1:0] BCNT_LAST = 3'h7;
  localparam logic [BCNT_W-1:0] BCNT_ONE  = 3'h1;
  localparam logic [BCNT_W-1:0] BCNT_ZERO = 3'h0;

  // Interrupt function codes, one-hot except FN_NONE
  localparam logic [FUNC_W-1:0] FN_NONE     = 6'h00;
  localparam logic [FUNC_W-1:0] FN_LHR_RDY  = 6'h20;
  localparam logic [FUNC_W-1:0] FN_L_HYST   = 6'h10;
  localparam logic [FUNC_W-1:0] FN_L_LATCH  = 6'h08;
  localparam logic [FUNC_W-1:0] FN_RPL_RDY  = 6'h04;
  localparam logic [FUNC_W-1:0] FN_RP_HYST  = 6'h02;
  localparam logic [FUNC_W-1:0] FN_RP_LATCH = 6'h01;

  typedef enum logic [1:0] {SPI_IDLE, SPI_ADDR, SPI_DATA} tic_spi_state_t;
endpackage : tic_pkg

// File: verilog/tic_reg_if.sv
// Register access carrier between the serial slave and the register bank.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface tic_reg_if;
  import tic_pkg::*;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              active;
  logic              sdo;

  modport spi  (output wr_en, wr_addr, wr_data, rd_addr, active, sdo, input rd_data);
  modport regs (input wr_en, wr_addr, wr_data, rd_addr, active, sdo, output rd_data);
endinterface : tic_reg_if
`default_nettype wire

// File: verilog/tic_spi_slave.sv
// Serial slave, mode 0: address byte (read flag in the top bit), then data bytes.
// Assumes the serial clock is far slower than the core clock; pins are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module tic_spi_slave
  import tic_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Serial pins
  input  wire logic spi_sck,
  input  wire logic spi_cs_n,
  input  wire logic spi_sdi,
  // Register side
  tic_reg_if.spi    bus
);
  logic [2:0]        sck_sync;
  logic [1:0]        cs_n_sync;
  logic [1:0]        sdi_sync;
  tic_spi_state_t    state,    next_state;
  logic [BCNT_W-1:0] bcnt,     next_bcnt;
  logic [DATA_W-1:0] shift,    next_shift;
  logic [DATA_W-1:0] txbuf,    next_txbuf;
  logic              is_read,  next_is_read;
  logic [ADDR_W-1:0] addr,     next_addr;
  logic              sdo,      next_sdo;
  logic              wr_en,    next_wr_en;
  logic [ADDR_W-1:0] wr_addr,  next_wr_addr;
  logic [DATA_W-1:0] wr_data,  next_wr_data;
  logic              rise;
  logic              fall;
  logic [DATA_W-1:0] byte_in;

  // Edges are taken only from the second and third stages
  assign rise    = sck_sync[1] & ~sck_sync[2];
  assign fall    = ~sck_sync[1] & sck_sync[2];
  assign byte_in = {shift[DATA_W-2:0], sdi_sync[1]};

  always_comb
  begin
    next_state   = state;
    next_bcnt    = bcnt;
    next_shift   = shift;
    next_txbuf   = txbuf;
    next_is_read = is_read;
    next_addr    = addr;
    next_sdo     = sdo;
    next_wr_en   = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    if (cs_n_sync[1])
    begin
      next_state = SPI_IDLE;
      next_bcnt  = BCNT_ZERO;
    end
    else
    begin
      case (state)
        SPI_IDLE:
          next_state = SPI_ADDR;
        SPI_ADDR:
          if (rise)
          begin
            next_shift = byte_in;
            next_bcnt  = bcnt + BCNT_ONE;
            if (bcnt == BCNT_LAST)
            begin
              next_is_read = byte_in[SPI_RW_BIT];
              next_addr    = byte_in[ADDR_W-1:0];
              next_state   = SPI_DATA;
            end
          end
        SPI_DATA:
          if (rise)
          begin
            next_shift = byte_in;
            next_bcnt  = bcnt + BCNT_ONE;
            if (bcnt == BCNT_LAST)
            begin
              // Bursts run on to the next address, both directions
              next_wr_en   = ~is_read;
              next_wr_addr = addr;
              next_wr_data = byte_in;
              next_addr    = addr + ADDR_ONE;
            end
          end
          else if (fall)
          begin
            if (bcnt == BCNT_ZERO)
            begin
              next_sdo   = bus.rd_data[DATA_W-1];
              next_txbuf = {bus.rd_data[DATA_W-2:0], 1'b0};
            end
            else
            begin
              next_sdo   = txbuf[DATA_W-1];
              next_txbuf = {txbuf[DATA_W-2:0], 1'b0};
            end
          end
        default:
          next_state = SPI_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_sync  <= 3'h0;
      cs_n_sync <= 2'h3;
      sdi_sync  <= 2'h0;
      state     <= SPI_IDLE;
      bcnt      <= BCNT_ZERO;
      shift     <= RD_NONE;
      txbuf     <= RD_NONE;
      is_read   <= 1'b0;
      addr      <= '0;
      sdo       <= 1'b0;
      wr_en     <= 1'b0;
      wr_addr   <= '0;
      wr_data   <= RD_NONE;
    end
    else
    begin
      sck_sync  <= {sck_sync[1:0], spi_sck};
      cs_n_sync <= {cs_n_sync[0], spi_cs_n};
      sdi_sync  <= {sdi_sync[0], spi_sdi};
      state     <= next_state;
      bcnt      <= next_bcnt;
      shift     <= next_shift;
      txbuf     <= next_txbuf;
      is_read   <= next_is_read;
      addr      <= next_addr;
      sdo       <= next_sdo;
      wr_en     <= next_wr_en;
      wr_addr   <= next_wr_addr;
      wr_data   <= next_wr_data;
    end
  end

  assign bus.wr_en   = wr_en;
  assign bus.wr_addr = wr_addr;
  assign bus.wr_data = wr_data;
  assign bus.rd_addr = addr;
  assign bus.active  = ~cs_n_sync[1];
  assign bus.sdo     = sdo;
endmodule : tic_spi_slave
`default_nettype wire

// File: verilog/tic_threshold_cfg.sv
// Contract
// - Threshold and interrupt-select writes are taken in any functional mode.
// - Upper resistance threshold is byte 0x07 high, byte 0x06 low.
// - Lower resistance threshold is byte 0x09 times 256 plus byte 0x08.
// - Low flag sets when resistance result is below the lower threshold.
// - Lower low byte is staged; applied when the high byte is written.
// - Four threshold bytes are read/write, eight bits, reset to 0x00.
// - Select bit 7 set routes interrupt to data-out; clear leaves pin alone.
// - Codes 0x20 and 0x04 report data ready; 0x00 gives no interrupt.
// - Code 0x10 inductance hysteresis; code 0x08 inductance upper latching.
// - Code 0x02 resistance hysteresis; code 0x01 resistance upper latching.
// - Functional-mode register at 0x0b resets to 0x01, writable any time.
// - High flag sets when resistance result exceeds the upper threshold.
// - Upper low byte is staged; applied when the high byte is written.
// - Inductance high flag sets when result exceeds its upper threshold.
//
// Register bank behind the serial port, threshold compare and interrupt select.
// Assumes conversion results and strobes come from the core on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tic_threshold_cfg
  import tic_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Serial pins
  input  wire logic              spi_sck,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_sdi,
  output logic                   sdo_out,
  output logic                   sdo_oe_n,
  // Interrupt pin
  output logic                   irq_out_n,
  // Conversion core
  input  wire logic              rp_valid,
  input  wire logic [RES_W-1:0]  resistance_result,
  input  wire logic              l_valid,
  input  wire logic [RES_W-1:0]  inductance_result,
  input  wire logic [RES_W-1:0]  l_upper_threshold,
  input  wire logic [RES_W-1:0]  l_lower_threshold,
  input  wire logic              lhr_ready,
  // Configuration and flags to the core
  output logic [RES_W-1:0]       rp_upper_threshold,
  output logic [RES_W-1:0]       rp_lower_threshold,
  output logic [DATA_W-1:0]      functional_mode_control,
  output logic                   resistance_high_flag,
  output logic                   resistance_low_flag,
  output logic                   inductance_high_flag,
  output logic                   inductance_low_flag
);
  tic_reg_if bus ();

  tic_spi_slave u_spi (
    .core_clk (core_clk),
    .nrst     (nrst),
    .spi_sck  (spi_sck),
    .spi_cs_n (spi_cs_n),
    .spi_sdi  (spi_sdi),
    .bus      (bus)
  );

  function automatic logic wr_hit(input logic en, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ref_a);
    wr_hit = en && (a == ref_a);
  endfunction : wr_hit

  logic [DATA_W-1:0] rp_upper_threshold_low_byte,  next_up_lo;
  logic [DATA_W-1:0] rp_upper_threshold_high_byte, next_up_hi;
  logic [DATA_W-1:0] rp_lower_threshold_low_byte,  next_lo_lo;
  logic [DATA_W-1:0] rp_lower_threshold_high_byte, next_lo_hi;
  logic [DATA_W-1:0] interrupt_select,             next_isel;
  logic [DATA_W-1:0] next_fmode;
  logic [RES_W-1:0]  next_rp_upper;
  logic [RES_W-1:0]  next_rp_lower;
  logic              next_rp_hi_flag, next_rp_lo_flag, next_l_hi_flag, next_l_lo_flag;
  logic              rp_hyst,  next_rp_hyst;
  logic              rp_latch, next_rp_latch;
  logic              l_hyst,   next_l_hyst;
  logic              l_latch,  next_l_latch;
  logic              next_irq_n;
  logic              next_sdo_out;
  logic              next_sdo_oe_n;
  logic              irq_on_data_out;
  logic [FUNC_W-1:0] irq_function;
  logic              rp_above, rp_below, l_above, l_below;
  logic              isel_wr;
  logic              irq_sel;

  assign irq_on_data_out = interrupt_select[ISEL_SDO_BIT];
  assign irq_function    = interrupt_select[ISEL_FUNC_MSB:0];
  assign rp_above        = rp_valid && (resistance_result > rp_upper_threshold);
  assign rp_below        = rp_valid && (resistance_result < rp_lower_threshold);
  assign l_above         = l_valid && (inductance_result > l_upper_threshold);
  assign l_below         = l_valid && (inductance_result < l_lower_threshold);
  assign isel_wr         = wr_hit(bus.wr_en, bus.wr_addr, ADDR_ISEL);

  // Register file: no mode gating, writes land while converting
  always_comb
  begin
    next_up_lo    = rp_upper_threshold_low_byte;
    next_up_hi    = rp_upper_threshold_high_byte;
    next_lo_lo    = rp_lower_threshold_low_byte;
    next_lo_hi    = rp_lower_threshold_high_byte;
    next_isel     = interrupt_select;
    next_fmode    = functional_mode_control;
    next_rp_upper = rp_upper_threshold;
    next_rp_lower = rp_lower_threshold;
    if (wr_hit(bus.wr_en, bus.wr_addr, ADDR_RP_UPPER_LO))
      next_up_lo = bus.wr_data;
    if (wr_hit(bus.wr_en, bus.wr_addr, ADDR_RP_UPPER_HI))
    begin
      next_up_hi    = bus.wr_data;
      next_rp_upper = {bus.wr_data, rp_upper_threshold_low_byte};
    end
    if (wr_hit(bus.wr_en, bus.wr_addr, ADDR_RP_LOWER_LO))
      next_lo_lo = bus.wr_data;
    if (wr_hit(bus.wr_en, bus.wr_addr, ADDR_RP_LOWER_HI))
    begin
      // Relies on the low byte having been written beforehand
      next_lo_hi    = bus.wr_data;
      next_rp_lower = {bus.wr_data, rp_lower_threshold_low_byte};
    end
    if (isel_wr)
      next_isel = bus.wr_data;
    if (wr_hit(bus.wr_en, bus.wr_addr, ADDR_FMODE))
      next_fmode = bus.wr_data;
  end

  // Read mux; staged bytes read back as written, unmapped reads give zero
  always_comb
  begin
    case (bus.rd_addr)
      ADDR_RP_UPPER_LO: bus.rd_data = rp_upper_threshold_low_byte;
      ADDR_RP_UPPER_HI: bus.rd_data = rp_upper_threshold_high_byte;
      ADDR_RP_LOWER_LO: bus.rd_data = rp_lower_threshold_low_byte;
      ADDR_RP_LOWER_HI: bus.rd_data = rp_lower_threshold_high_byte;
      ADDR_ISEL:        bus.rd_data = interrupt_select;
      ADDR_FMODE:       bus.rd_data = functional_mode_control;
      default:          bus.rd_data = RD_NONE;
    endcase
  end

  // Compare flags and interrupt state
  always_comb
  begin
    next_rp_hi_flag = rp_valid ? rp_above : resistance_high_flag;
    next_rp_lo_flag = rp_valid ? rp_below : resistance_low_flag;
    next_l_hi_flag  = l_valid ? l_above : inductance_high_flag;
    next_l_lo_flag  = l_valid ? l_below : inductance_low_flag;
    next_rp_hyst    = rp_above ? 1'b1 : (rp_below ? 1'b0 : rp_hyst);
    next_l_hyst     = l_above ? 1'b1 : (l_below ? 1'b0 : l_hyst);
    // Latch clears on a select write; a new crossing in that cycle wins
    next_rp_latch   = rp_above | (rp_latch & ~isel_wr);
    next_l_latch    = l_above | (l_latch & ~isel_wr);
    case (irq_function)
      FN_LHR_RDY:  irq_sel = lhr_ready;
      FN_RPL_RDY:  irq_sel = rp_valid;
      FN_L_HYST:   irq_sel = next_l_hyst;
      FN_L_LATCH:  irq_sel = next_l_latch;
      FN_RP_HYST:  irq_sel = next_rp_hyst;
      FN_RP_LATCH: irq_sel = next_rp_latch;
      default:     irq_sel = 1'b0;
    endcase
    next_irq_n = ~irq_sel;
    // Outside a transfer the pin carries the interrupt only when routed
    next_sdo_out  = bus.active ? bus.sdo : irq_out_n;
    next_sdo_oe_n = ~(bus.active | irq_on_data_out);
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rp_upper_threshold_low_byte  <= THR_RST;
      rp_upper_threshold_high_byte <= THR_RST;
      rp_lower_threshold_low_byte  <= THR_RST;
      rp_lower_threshold_high_byte <= THR_RST;
      interrupt_select             <= ISEL_RST;
      functional_mode_control      <= FMODE_RST;
      rp_upper_threshold           <= {THR_RST, THR_RST};
      rp_lower_threshold           <= {THR_RST, THR_RST};
      resistance_high_flag         <= 1'b0;
      resistance_low_flag          <= 1'b0;
      inductance_high_flag         <= 1'b0;
      inductance_low_flag          <= 1'b0;
      rp_hyst                      <= 1'b0;
      rp_latch                     <= 1'b0;
      l_hyst                       <= 1'b0;
      l_latch                      <= 1'b0;
      irq_out_n                    <= 1'b1;
      sdo_out                      <= 1'b0;
      sdo_oe_n                     <= 1'b1;
    end
    else
    begin
      rp_upper_threshold_low_byte  <= next_up_lo;
      rp_upper_threshold_high_byte <= next_up_hi;
      rp_lower_threshold_low_byte  <= next_lo_lo;
      rp_lower_threshold_high_byte <= next_lo_hi;
      interrupt_select             <= next_isel;
      functional_mode_control      <= next_fmode;
      rp_upper_threshold           <= next_rp_upper;
      rp_lower_threshold           <= next_rp_lower;
      resistance_high_flag         <= next_rp_hi_flag;
      resistance_low_flag          <= next_rp_lo_flag;
      inductance_high_flag         <= next_l_hi_flag;
      inductance_low_flag          <= next_l_lo_flag;
      rp_hyst                      <= next_rp_hyst;
      rp_latch                     <= next_rp_latch;
      l_hyst                       <= next_l_hyst;
      l_latch                      <= next_l_latch;
      irq_out_n                    <= next_irq_n;
      sdo_out                      <= next_sdo_out;
      sdo_oe_n                     <= next_sdo_oe_n;
    end
  end

  // Checks
  sequence s_low_byte_written;
    wr_hit(bus.wr_en, bus.wr_addr, ADDR_RP_LOWER_LO);
  endsequence

  sequence s_no_high_write;
    !wr_hit(bus.wr_en, bus.wr_addr, ADDR_RP_LOWER_HI);
  endsequence

  AST_UPPER_PAIR: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_hit(bus.wr_en, bus.wr_addr, ADDR_RP_UPPER_HI)
      |=> rp_upper_threshold == {$past(bus.wr_data), $past(rp_upper_threshold_low_byte)})
    else $error("upper threshold not formed from high and staged low byte");

  AST_LOWER_PAIR: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_hit(bus.wr_en, bus.wr_addr, ADDR_RP_LOWER_HI)
      |=> rp_lower_threshold == ({8'h00, $past(bus.wr_data)} * 16'h0100) + {8'h00, $past(rp_lower_threshold_low_byte)})
    else $error("lower threshold not high times 256 plus low");

  AST_LOWER_STAGED: assert property (@(posedge core_clk) disable iff (!nrst)
    (s_low_byte_written ##1 s_no_high_write) |-> $stable(rp_lower_threshold))
    else $error("lower low byte reached the active threshold without a high byte");

  AST_UPPER_STAGED: assert property (@(posedge core_clk) disable iff (!nrst)
    !wr_hit(bus.wr_en, bus.wr_addr, ADDR_RP_UPPER_HI) |=> $stable(rp_upper_threshold))
    else $error("upper threshold changed without a high byte write");

  AST_LOW_FLAG: assert property (@(posedge core_clk) disable iff (!nrst)
    rp_valid |=> resistance_low_flag == ($past(resistance_result) < $past(rp_lower_threshold)))
    else $error("low flag does not match strict compare");

  AST_HIGH_FLAG: assert property (@(posedge core_clk) disable iff (!nrst)
    rp_valid |=> resistance_high_flag == ($past(resistance_result) > $past(rp_upper_threshold)))
    else $error("high flag does not match strict compare");

  AST_L_HIGH_FLAG: assert property (@(posedge core_clk) disable iff (!nrst)
    l_valid |=> inductance_high_flag == ($past(inductance_result) > $past(l_upper_threshold)))
    else $error("inductance high flag does not match strict compare");

  AST_NO_IRQ: assert property (@(posedge core_clk) disable iff (!nrst)
    (irq_function == FN_NONE) |=> irq_out_n)
    else $error("interrupt asserted with no function selected");

  AST_RP_LATCH: assert property (@(posedge core_clk) disable iff (!nrst)
    (irq_function == FN_RP_LATCH && rp_above && !isel_wr) ##1 (!isel_wr)[*2] |=> !irq_out_n)
    else $error("latching interrupt released while selected");

  AST_RP_HYST: assert property (@(posedge core_clk) disable iff (!nrst)
    (irq_function == FN_RP_HYST && rp_hyst && !rp_below) |=> !irq_out_n)
    else $error("hysteresis interrupt cleared without a low crossing");

  AST_PIN_FREE: assert property (@(posedge core_clk) disable iff (!nrst)
    (!bus.active && !irq_on_data_out) |=> sdo_oe_n)
    else $error("data-out driven outside a transfer without routing");

  AST_PIN_IRQ: assert property (@(posedge core_clk) disable iff (!nrst)
    (!bus.active && irq_on_data_out) |=> (!sdo_oe_n && sdo_out == $past(irq_out_n)))
    else $error("routed interrupt not on data-out");

  AST_FMODE_WR: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_hit(bus.wr_en, bus.wr_addr, ADDR_FMODE) |=> functional_mode_control == $past(bus.wr_data))
    else $error("functional mode write lost");

  // A select write in the same cycle would change the code under the check
  sequence s_l_latch_set;
    irq_function == FN_L_LATCH && l_above && !isel_wr;
  endsequence

  AST_L_LATCH: assert property (@(posedge core_clk) disable iff (!nrst)
    s_l_latch_set ##1 (!isel_wr)[*2] |=> !irq_out_n)
    else $error("inductance latching interrupt released while selected");

  AST_L_HYST: assert property (@(posedge core_clk) disable iff (!nrst)
    (irq_function == FN_L_HYST && l_hyst && !l_below) |=> !irq_out_n)
    else $error("inductance hysteresis interrupt cleared without a low crossing");

  AST_RPL_READY: assert property (@(posedge core_clk) disable iff (!nrst)
    (irq_function == FN_RPL_RDY) |=> (irq_out_n == !$past(rp_valid)))
    else $error("data ready interrupt does not follow the result strobe");

  AST_LHR_READY: assert property (@(posedge core_clk) disable iff (!nrst)
    (irq_function == FN_LHR_RDY) |=> (irq_out_n == !$past(lhr_ready)))
    else $error("high-res ready interrupt does not follow its strobe");
endmodule : tic_threshold_cfg
`default_nettype wire

// File: sim/tic_spi_host.sv
// Host model: drives the serial pins of the bank, one address-and-data frame at a time.
// Assumes mode 0 and the core clock of the bank for its pacing.
`timescale 1ns/1ps
`default_nettype none
module tic_spi_host (
  // Clock
  input  wire logic core_clk,
  // Serial pins
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_sdi,
  input  wire logic sdo_out,
  input  wire logic sdo_oe_n
);
  initial {spi_sck, spi_cs_n, spi_sdi} = 3'h2;
  // Eight core cycles a half period leaves margin over the pin synchroniser
  task automatic bits(input logic [7:0] o, output logic [7:0] i);
    for (int k = 7; k >= 0; k--)
    begin
      spi_sdi = o[k];
      repeat (8) @(negedge core_clk);
      spi_sck = 1'b1;
      // A released line does not keep the last bit
      i[k] = sdo_oe_n ? ~o[k] : sdo_out;
      repeat (8) @(negedge core_clk);
      spi_sck = 1'b0;
    end
  endtask : bits
  // Select stays low long enough for the write to land first
  task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] s;
    spi_cs_n = 1'b0;
    repeat (8) @(negedge core_clk);
    bits({r, a}, s);
    bits(d, q);
    spi_sdi = ~spi_sdi;
    repeat (8) @(negedge core_clk);
    spi_cs_n = 1'b1;
    repeat (8) @(negedge core_clk);
  endtask : xfer
endmodule : tic_spi_host
`default_nettype wire

// File: sim/threshold_interrupt_config_tb_top.sv
// Bench for the threshold bank: registers over the serial port, flags, interrupt.
// Assumes the host model tic_spi_host.
`timescale 1ns/1ps
`default_nettype none
module threshold_interrupt_config_tb_top;
  import tic_pkg::*;
  typedef struct packed {logic [6:0] a; logic [7:0] d; logic [15:0] up, lo;} tic_row_t;
  typedef struct packed {logic [7:0] s; logic [1:0] k; logic [15:0] v; logic n;} tic_ev_t;
  logic              core_clk = 1'b0, nrst = 1'b0, rp_valid = 1'b0, l_valid = 1'b0, lhr_ready = 1'b0;
  logic              spi_sck, spi_cs_n, spi_sdi, sdo_out, sdo_oe_n, irq_out_n;
  logic              resistance_high_flag, resistance_low_flag, inductance_high_flag, inductance_low_flag;
  logic [RES_W-1:0]  resistance_result = 16'h0, inductance_result = 16'h0;
  logic [RES_W-1:0]  l_upper_threshold = 16'h2000, l_lower_threshold = 16'h1000;
  logic [RES_W-1:0]  rp_upper_threshold, rp_lower_threshold;
  logic [DATA_W-1:0] functional_mode_control, q, cur = 8'h00;
  int                error_cnt = 0, num_checks = 0;
  tic_row_t rows[6] = '{'{7'h0b, 8'h00, 16'h0, 16'h0}, '{7'h06, 8'h34, 16'h0, 16'h0},
    '{7'h07, 8'h12, 16'h1234, 16'h0}, '{7'h08, 8'h80, 16'h1234, 16'h0},
    '{7'h09, 8'h01, 16'h1234, 16'h0180}, '{7'h07, 8'h13, 16'h1334, 16'h0180}};
  tic_ev_t evs[17] = '{'{8'h00, 2'h0, 16'h1335, 1'b1}, '{8'h00, 2'h0, 16'h1334, 1'b1},
    '{8'h00, 2'h0, 16'h017f, 1'b1}, '{8'h00, 2'h0, 16'h0180, 1'b1}, '{8'h04, 2'h0, 16'h0, 1'b0},
    '{8'h20, 2'h2, 16'h0, 1'b0}, '{8'h01, 2'h0, 16'h2000, 1'b0}, '{8'h01, 2'h0, 16'h0, 1'b0},
    '{8'h02, 2'h0, 16'h2000, 1'b0}, '{8'h02, 2'h0, 16'h1000, 1'b0}, '{8'h02, 2'h0, 16'h0100, 1'b1},
    '{8'h10, 2'h1, 16'h2001, 1'b0}, '{8'h10, 2'h1, 16'h1800, 1'b0}, '{8'h10, 2'h1, 16'h0fff, 1'b1},
    '{8'h08, 2'h1, 16'h2001, 1'b0}, '{8'h08, 2'h1, 16'h0, 1'b0}, '{8'h04, 2'h2, 16'h0, 1'b1}};
  tic_threshold_cfg uut (.core_clk, .nrst, .spi_sck, .spi_cs_n, .spi_sdi, .sdo_out, .sdo_oe_n,
    .irq_out_n, .rp_valid, .resistance_result, .l_valid, .inductance_result, .l_upper_threshold,
    .l_lower_threshold, .lhr_ready, .rp_upper_threshold, .rp_lower_threshold,
    .functional_mode_control, .resistance_high_flag, .resistance_low_flag,
    .inductance_high_flag, .inductance_low_flag);
  tic_spi_host host (.core_clk, .spi_sck, .spi_cs_n, .spi_sdi, .sdo_out, .sdo_oe_n);
  always #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    host.xfer(1'b1, a, 8'h00, q);
    chk(q, e);
  endtask : rd
  task automatic ev(input logic [1:0] k, input logic [15:0] v);
    resistance_result = v;
    inductance_result = v;
    {rp_valid, l_valid, lhr_ready} = {k == 2'h0, k == 2'h1, k == 2'h2};
    @(negedge core_clk);
    // Returns after the one-cycle ready pulse has been dropped
    {rp_valid, l_valid, lhr_ready} = 3'h0;
  endtask : ev
  task automatic stop_test;
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  initial
  begin
    #200us;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
    for (int i = 6; i < 12; i++)
      rd(7'(i), i == 11 ? 8'h01 : 8'h00);
    chk(irq_out_n, 1'b1);
    $display("Reset values done");
    // Low byte before high byte throughout
    foreach (rows[i])
    begin
      host.xfer(1'b0, rows[i].a, rows[i].d, q);
      rd(rows[i].a, rows[i].d);
      chk(rp_upper_threshold, rows[i].up);
      chk(rp_lower_threshold, rows[i].lo);
    end
    chk(functional_mode_control, 8'h00);
    $display("Register rows done");
    // Bit 6 is always written zero
    foreach (evs[i])
    begin
      if (evs[i].s != cur)
        host.xfer(1'b0, ADDR_ISEL, evs[i].s, q);
      cur = evs[i].s;
      ev(evs[i].k, evs[i].v);
      chk(irq_out_n, evs[i].n);
      if (evs[i].k == 2'h0)
      begin
        chk(resistance_high_flag, evs[i].v > 16'h1334);
        chk(resistance_low_flag, evs[i].v < 16'h0180);
      end
      if (evs[i].k == 2'h1)
      begin
        chk(inductance_high_flag, evs[i].v > 16'h2000);
        chk(inductance_low_flag, evs[i].v < 16'h1000);
      end
      @(negedge core_clk);
    end
    $display("Interrupt rows done");
    host.xfer(1'b0, ADDR_ISEL, 8'h88, q);
    ev(2'h1, 16'h2001);
    repeat (2) @(negedge core_clk);
    chk({sdo_oe_n, sdo_out}, 2'h0);
    host.xfer(1'b0, ADDR_ISEL, 8'h08, q);
    chk(sdo_oe_n, 1'b1);
    host.xfer(1'b0, 7'h30, 8'h5a, q);
    rd(7'h30, 8'h00);
    $display("Routing and unmapped done");
    nrst = 1'b0;
    @(negedge core_clk);
    chk(rp_upper_threshold, 16'h0);
    chk(functional_mode_control, 8'h01);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
    rd(ADDR_FMODE, FMODE_RST);
    $display("Second reset done");
    stop_test();
  end
endmodule : threshold_interrupt_config_tb_top
`default_nettype wire
